//--- hdl/idf_pkg.sv
// constants and types shared by the input debounce and chatter filter
// assumes one 100 MHz clock; every input is sampled once per millisecond tick
package idf_pkg;
    localparam int NUM_INPUTS = 32;
    localparam int BLOCK_SIZE = 8;
    localparam int NUM_BLOCKS = NUM_INPUTS / BLOCK_SIZE;
    localparam int NUM_PAIRS = NUM_INPUTS / 2;
    localparam int TIME_W = 8;
    localparam int COUNT_W = 32;
    localparam int WIN_W = 15;
    localparam int MODE_W = 2;
    localparam int STATUS_W = 16;
    localparam int STATUS_CHATTER_BIT = 7;

    // sample tick and clock period
    localparam int CLK_PERIOD_NS = 10;
    localparam int SAMPLE_PERIOD_MS = 1;
    localparam int SAMPLE_PERIOD_NS = SAMPLE_PERIOD_MS * 1000000;
    localparam int TICK_CYCLES = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;

    // chatter window granularity
    localparam int WINDOW_UNIT_MS = 100;
    localparam int WINDOW_UNIT_TICKS = WINDOW_UNIT_MS / SAMPLE_PERIOD_MS;

    // zero, minimum-window, count-step and last-window constants
    localparam logic [TIME_W-1:0] TIME_ZERO = 8'h00;
    localparam logic [TIME_W-1:0] WINDOW_MIN = 8'h01;
    localparam logic [COUNT_W-1:0] COUNT_ZERO = 32'h0000_0000;
    localparam logic [COUNT_W-1:0] COUNT_STEP = 32'h0000_0001;
    localparam logic [WIN_W-1:0] WIN_LAST = 15'h0001;
    localparam logic [WIN_W-1:0] WIN_ZERO = 15'h0000;

    // function of a block of eight inputs
    typedef enum logic [MODE_W-1:0] {
        IDF_MODE_BINARY,
        IDF_MODE_EVENT,
        IDF_MODE_COUNTER
    } idf_mode_e;
endpackage : idf_pkg

//--- hdl/idf_debounce.sv
// one input's debounce stage, stable-signal or integrating
// assumes tick is a one-cycle pulse once per millisecond
`timescale 1ns/1ns
`default_nettype none
module idf_debounce
    import idf_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic tick,
    input wire logic raw,
    input wire logic [TIME_W-1:0] filt_time,
    input wire logic integrate,
    output logic level
);
    logic level_q;
    logic [TIME_W-1:0] cnt_q;
    logic [TIME_W-1:0] cnt_d;
    logic level_d;
    logic differs;
    logic [TIME_W:0] cnt_inc;
    logic stable_ok;
    logic integ_ok;
    logic accept;

    // acceptance decode; stable needs time+1 equal samples, i.e. longer than time
    assign differs = raw != level_q;
    assign cnt_inc = {1'b0, cnt_q} + {{TIME_W{1'b0}}, 1'b1};
    assign stable_ok = differs && cnt_q >= filt_time;
    assign integ_ok = differs && cnt_inc >= {1'b0, filt_time};
    assign accept = (filt_time == TIME_ZERO) || (integrate ? integ_ok : stable_ok);
    assign level_d = accept ? raw : level_q;
    // stable restarts on any reversion, integrating walks back down
    assign cnt_d = accept ? TIME_ZERO :
                   differs ? cnt_inc[TIME_W-1:0] :
                   (integrate && cnt_q != TIME_ZERO) ? cnt_q - 8'h01 : TIME_ZERO;

    // state only moves on the sample tick
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            level_q <= 1'b0;
            cnt_q <= TIME_ZERO;
        end else if (tick) begin
            level_q <= level_d;
            cnt_q <= cnt_d;
        end
    end

    assign level = level_q;

    AST_BYPASS: assert property (@(posedge clk) disable iff (!rst_b)
        tick && filt_time == TIME_ZERO |=> level_q == $past(raw))
        else $error("zero debounce time did not pass input through");
    AST_HOLD_OFF_TICK: assert property (@(posedge clk) disable iff (!rst_b)
        !tick |=> $stable(level_q))
        else $error("debounced level moved outside a sample tick");
endmodule : idf_debounce
`default_nettype wire

//--- hdl/idf_input_filter.sv
// 32-input preprocessing: enable, invert, debounce, chatter filter, edge, count
// assumes pins and configuration ports are synchronous to MCLK and held steady
//
// What this block does
// - sample all 32 inputs once per millisecond; filters advance on that tick
// - four blocks of eight inputs, each binary, event or counter
// - a disabled input is fed to the debounce stage as zero
// - inversion complements the input before all later stages
// - edge selection takes both edges or rising only, after inversion
// - debounce time 0 to 255 ms; zero bypasses the filter
// - stable or integrating method chosen once per block
// - stable mode accepts a level held longer than the time; changes restart
// - integrating mode accepts when an up/down accumulator reaches the time
// - dechattering only on event and counter inputs, caps events per window
// - chatter limit per input, chatter window per input pair
// - block dechatter enable covers all eight; limit zero leaves input unfiltered
// - chatter limit 1 to 255 events per window; zero disables
// - window 1 to 255 units of 100 ms
// - status bit 7 set while any input suppressed, cleared as windows expire
// - odd limit with both edges may pass two same-direction events
// - counter inputs sum accepted edges in 32 bits, up to 500 Hz
// - order is enable, invert, debounce, chatter, edge recognition
// - binary value is taken straight after debounce
`timescale 1ns/1ns
`default_nettype none
module idf_input_filter
    import idf_pkg::*;
#(
    parameter int TICK_CYCLES_P = TICK_CYCLES
) (
    input wire logic MCLK,
    input wire logic RST_B,
    input wire logic [NUM_INPUTS-1:0] IN_PINS,
    input wire logic [NUM_INPUTS-1:0] IN_DISABLE,
    input wire logic [NUM_INPUTS-1:0] IN_INVERT,
    input wire logic [NUM_INPUTS-1:0] IN_BOTH_EDGES,
    input wire logic [NUM_INPUTS*TIME_W-1:0] DEBOUNCE_TIME,
    input wire logic [NUM_INPUTS*TIME_W-1:0] CHATTER_LIMIT,
    input wire logic [NUM_PAIRS*TIME_W-1:0] CHATTER_WINDOW,
    input wire logic [NUM_BLOCKS*MODE_W-1:0] BLOCK_MODE,
    input wire logic [NUM_BLOCKS-1:0] BLOCK_INTEGRATE,
    input wire logic [NUM_BLOCKS-1:0] BLOCK_DECHATTER,
    output logic SAMPLE_TICK,
    output logic [NUM_INPUTS-1:0] BIN_VALUE,
    output logic [NUM_INPUTS-1:0] EVENT_STROBE,
    output logic [NUM_INPUTS*COUNT_W-1:0] COUNT_VALUES,
    output logic CHATTER_FILTER_ACTIVE_FLAG,
    output logic [STATUS_W-1:0] STATUS_WORD
);
    localparam int DIV_W = $clog2(TICK_CYCLES_P);

    // the divider needs at least two states to give a one-cycle tick
    if (TICK_CYCLES_P < 2) begin : g_bad_tick
        $error("TICK_CYCLES_P must be at least 2");
    end

    // true when a block's inputs go through chatter and edge stages
    function automatic logic edge_mode(input logic [MODE_W-1:0] m);
        edge_mode = idf_mode_e'(m) == IDF_MODE_EVENT || idf_mode_e'(m) == IDF_MODE_COUNTER;
    endfunction : edge_mode

    // one block's function code compared against a wanted mode
    function automatic logic mode_is(input logic [MODE_W-1:0] m, input idf_mode_e want);
        mode_is = idf_mode_e'(m) == want;
    endfunction : mode_is

    logic [DIV_W-1:0] div_q;
    logic tick_q;
    logic [NUM_INPUTS-1:0] pre_w;
    logic [NUM_INPUTS-1:0] db_w;
    logic [NUM_INPUTS-1:0] db_prev_q;
    logic [NUM_INPUTS-1:0] chg_w;
    logic [NUM_INPUTS-1:0] chat_on_w;
    logic [NUM_INPUTS-1:0] limit_hit_w;
    logic [NUM_INPUTS-1:0] pass_w;
    logic [NUM_INPUTS-1:0] acc_w;
    logic [NUM_INPUTS-1:0] supp_q;
    logic [NUM_INPUTS-1:0] bin_q;
    logic [NUM_INPUTS-1:0] strobe_q;
    logic [NUM_PAIRS-1:0] win_exp_w;
    logic [NUM_PAIRS-1:0] win_run_q;
    logic [COUNT_W-1:0] cnt_q [NUM_INPUTS];
    logic flag_q;
    logic [STATUS_W-1:0] status_q;
    logic [STATUS_W-1:0] status_d;
    logic any_supp_w;
    logic [NUM_INPUTS-1:0] edge_in_w;
    logic [NUM_INPUTS-1:0] counter_in_w;
    logic [NUM_INPUTS-1:0] event_in_w;

    // millisecond sample tick from the 100 MHz clock
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            div_q <= '0;
            tick_q <= 1'b0;
        end else begin
            div_q <= (div_q == DIV_W'(TICK_CYCLES_P - 1)) ? '0 : div_q + DIV_W'(1);
            tick_q <= div_q == DIV_W'(TICK_CYCLES_P - 1);
        end
    end

    // per-input pipeline; a debounced level moves at most once per tick
    for (genvar i = 0; i < NUM_INPUTS; i++) begin : g_in
        localparam int BLK = i / BLOCK_SIZE;
        localparam int PAIR = i / 2;
        logic [TIME_W-1:0] limit_w;
        logic [TIME_W-1:0] evc_q;
        logic [TIME_W-1:0] evc_eff_w;
        logic blk_edge_w;
        logic blk_counter_w;
        logic blk_event_w;

        assign limit_w = CHATTER_LIMIT[i*TIME_W +: TIME_W];
        assign blk_edge_w = edge_mode(BLOCK_MODE[BLK*MODE_W +: MODE_W]);
        assign blk_counter_w = mode_is(BLOCK_MODE[BLK*MODE_W +: MODE_W], IDF_MODE_COUNTER);
        assign blk_event_w = mode_is(BLOCK_MODE[BLK*MODE_W +: MODE_W], IDF_MODE_EVENT);
        // flat copies of the block decode for the checks below
        assign edge_in_w[i] = blk_edge_w;
        assign counter_in_w[i] = blk_counter_w;
        assign event_in_w[i] = blk_event_w;

        // enable first, then inversion, ahead of the debounce stage
        assign pre_w[i] = IN_DISABLE[i] ? 1'b0 : IN_PINS[i] ^ IN_INVERT[i];

        idf_debounce u_db (
            .clk(MCLK),
            .rst_b(RST_B),
            .tick(tick_q),
            .raw(pre_w[i]),
            .filt_time(DEBOUNCE_TIME[i*TIME_W +: TIME_W]),
            .integrate(BLOCK_INTEGRATE[BLK]),
            .level(db_w[i])
        );

        // chatter decode; an expiring window frees the count in the same cycle
        assign chg_w[i] = db_w[i] ^ db_prev_q[i];
        assign chat_on_w[i] = BLOCK_DECHATTER[BLK] && blk_edge_w && limit_w != TIME_ZERO;
        assign evc_eff_w = win_exp_w[PAIR] ? TIME_ZERO : evc_q;
        assign limit_hit_w[i] = chat_on_w[i] && evc_eff_w >= limit_w;
        assign pass_w[i] = chg_w[i] && blk_edge_w && !limit_hit_w[i];
        // direction is the debounced level itself, so odd limits can repeat an edge
        assign acc_w[i] = pass_w[i] && (IN_BOTH_EDGES[i] || db_w[i]);

        // event count and suppression; a new event wins over the window clear
        always_ff @(posedge MCLK or negedge RST_B) begin
            if (!RST_B) begin
                evc_q <= TIME_ZERO;
                supp_q[i] <= 1'b0;
            end else begin
                evc_q <= (chg_w[i] && chat_on_w[i] && !limit_hit_w[i]) ?
                         evc_eff_w + 8'h01 : evc_eff_w;
                supp_q[i] <= (chg_w[i] && limit_hit_w[i]) ? 1'b1 :
                             win_exp_w[PAIR] ? 1'b0 : supp_q[i];
            end
        end

        // 32-bit total wraps silently; rate is bounded by the 1 ms sample
        always_ff @(posedge MCLK or negedge RST_B) begin
            if (!RST_B) begin
                cnt_q[i] <= COUNT_ZERO;
                strobe_q[i] <= 1'b0;
            end else begin
                cnt_q[i] <= (acc_w[i] && blk_counter_w) ? cnt_q[i] + COUNT_STEP : cnt_q[i];
                strobe_q[i] <= acc_w[i] && blk_event_w;
            end
        end

        assign COUNT_VALUES[i*COUNT_W +: COUNT_W] = cnt_q[i];
    end

    // one chatter window per input pair, opened by the first counted change
    for (genvar p = 0; p < NUM_PAIRS; p++) begin : g_pair
        logic [TIME_W-1:0] win_set_w;
        logic [WIN_W-1:0] win_len_w;
        logic [WIN_W-1:0] win_q;
        logic start_w;

        // a zero window setting is taken as the smallest legal one
        assign win_set_w = (CHATTER_WINDOW[p*TIME_W +: TIME_W] == TIME_ZERO) ?
                           WINDOW_MIN : CHATTER_WINDOW[p*TIME_W +: TIME_W];
        assign win_len_w = WIN_W'(int'(win_set_w) * WINDOW_UNIT_TICKS);
        assign start_w = !win_run_q[p] && |(chg_w[2*p +: 2] & chat_on_w[2*p +: 2]);
        assign win_exp_w[p] = win_run_q[p] && tick_q && win_q == WIN_LAST;

        always_ff @(posedge MCLK or negedge RST_B) begin
            if (!RST_B) begin
                win_q <= WIN_ZERO;
                win_run_q[p] <= 1'b0;
            end else if (start_w) begin
                win_q <= win_len_w;
                win_run_q[p] <= 1'b1;
            end else if (win_exp_w[p]) begin
                win_run_q[p] <= 1'b0;
            end else if (win_run_q[p] && tick_q) begin
                win_q <= win_q - WIN_LAST;
            end
        end
    end

    // only the chatter bit is defined, the rest of the word reads zero
    assign any_supp_w = |supp_q;
    assign status_d = STATUS_W'(any_supp_w) << STATUS_CHATTER_BIT;

    // binary value registered straight after debounce, with flag and status
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            db_prev_q <= '0;
            bin_q <= '0;
            flag_q <= 1'b0;
            status_q <= '0;
        end else begin
            db_prev_q <= db_w;
            bin_q <= db_w;
            flag_q <= any_supp_w;
            status_q <= status_d;
        end
    end

    assign SAMPLE_TICK = tick_q;
    assign BIN_VALUE = bin_q;
    assign EVENT_STROBE = strobe_q;
    assign CHATTER_FILTER_ACTIVE_FLAG = flag_q;
    assign STATUS_WORD = status_q;

    AST_TICK_SINGLE: assert property (@(posedge MCLK) disable iff (!RST_B)
        tick_q |=> !tick_q)
        else $error("sample tick lasted more than one cycle");
    AST_BIN_AFTER_DB: assert property (@(posedge MCLK) disable iff (!RST_B)
        ##1 bin_q == $past(db_w))
        else $error("binary value is not the debounced level");
    AST_DISABLED_ZERO: assert property (@(posedge MCLK) disable iff (!RST_B)
        (pre_w & IN_DISABLE) == '0)
        else $error("disabled input reached the debounce stage as one");
    AST_PASS_NEEDS_CHANGE: assert property (@(posedge MCLK) disable iff (!RST_B)
        (pass_w & ~chg_w) == '0)
        else $error("event passed without a debounced change");
    AST_SUPPRESSED_BLOCKS: assert property (@(posedge MCLK) disable iff (!RST_B)
        (chg_w & limit_hit_w) != '0 |=> supp_q != '0 ##1 CHATTER_FILTER_ACTIVE_FLAG)
        else $error("suppressed event did not raise the chatter flag");
    AST_FLAG_STATUS: assert property (@(posedge MCLK) disable iff (!RST_B)
        STATUS_WORD[STATUS_CHATTER_BIT] == CHATTER_FILTER_ACTIVE_FLAG)
        else $error("status bit 7 differs from the chatter flag");
    AST_COUNT_STEP: assert property (@(posedge MCLK) disable iff (!RST_B)
        acc_w[8] && counter_in_w[8]
        |=> cnt_q[8] == $past(cnt_q[8]) + COUNT_STEP)
        else $error("counter input 8 missed an accepted edge");
    AST_RISING_ONLY: assert property (@(posedge MCLK) disable iff (!RST_B)
        acc_w[8] && !IN_BOTH_EDGES[8] |-> db_w[8])
        else $error("falling edge accepted with single-edge selection");

    // chatter and window checks on the pair of inputs 16 and 17, then flag and status checks across all inputs
    AST_EVENT_CAP: assert property (@(posedge MCLK) disable iff (!RST_B)
        chat_on_w[16] |-> !(g_in[16].evc_q > CHATTER_LIMIT[16*TIME_W +: TIME_W]))
        else $error("input 16 counted more events than its chatter limit");
    AST_SUPP_NO_STROBE: assert property (@(posedge MCLK) disable iff (!RST_B)
        chg_w[16] && limit_hit_w[16] |=> !strobe_q[16])
        else $error("suppressed change on input 16 still gave a strobe");
    AST_LIMIT_ZERO_OPEN: assert property (@(posedge MCLK) disable iff (!RST_B)
        chg_w[17] && edge_in_w[17] && CHATTER_LIMIT[17*TIME_W +: TIME_W] == TIME_ZERO
        |-> pass_w[17])
        else $error("input 17 with limit zero had a change dropped");
    AST_WINDOW_LOAD: assert property (@(posedge MCLK) disable iff (!RST_B)
        g_pair[8].start_w |=> g_pair[8].win_q == $past(g_pair[8].win_len_w))
        else $error("chatter window of pair 8 not loaded with its length");
    AST_WINDOW_HOLD: assert property (@(posedge MCLK) disable iff (!RST_B)
        win_run_q[8] && !tick_q |=> $stable(g_pair[8].win_q))
        else $error("chatter window of pair 8 moved outside a sample tick");
    AST_WINDOW_CLEAR: assert property (@(posedge MCLK) disable iff (!RST_B)
        win_exp_w[8] && !(chg_w[16] && limit_hit_w[16]) |=> !supp_q[16])
        else $error("input 16 still suppressed after its window expired");
    AST_FLAG_DROP: assert property (@(posedge MCLK) disable iff (!RST_B)
        $fell(CHATTER_FILTER_ACTIVE_FLAG) |-> $past(win_exp_w, 2) != '0)
        else $error("chatter flag fell without a window expiry");
    AST_STATUS_OTHER_ZERO: assert property (@(posedge MCLK) disable iff (!RST_B)
        (STATUS_WORD & ~(STATUS_W'(1'b1) << STATUS_CHATTER_BIT)) == '0)
        else $error("status word has a bit set besides the chatter bit");

    // block function and input polarity checks
    AST_STROBE_EVENT_ONLY: assert property (@(posedge MCLK) disable iff (!RST_B)
        (EVENT_STROBE & ~event_in_w) == '0)
        else $error("event strobe from an input outside an event block");
    AST_STROBE_SINGLE: assert property (@(posedge MCLK) disable iff (!RST_B)
        strobe_q[16] |=> !strobe_q[16])
        else $error("event strobe of input 16 lasted more than one cycle");
    AST_BINARY_NO_COUNT: assert property (@(posedge MCLK) disable iff (!RST_B)
        !counter_in_w[0] |=> $stable(cnt_q[0]))
        else $error("count of input 0 moved outside a counter block");
    AST_COUNT_HOLD: assert property (@(posedge MCLK) disable iff (!RST_B)
        !acc_w[8] |=> $stable(cnt_q[8]))
        else $error("count of input 8 moved without an accepted edge");
    AST_INVERT: assert property (@(posedge MCLK) disable iff (!RST_B)
        ((pre_w ^ IN_PINS) & ~IN_DISABLE) == (IN_INVERT & ~IN_DISABLE))
        else $error("enabled input polarity does not follow its invert bit");

    COV_COUNT: cover property (@(posedge MCLK) disable iff (!RST_B) cnt_q[0] != COUNT_ZERO);
    COV_EVENT: cover property (@(posedge MCLK) disable iff (!RST_B) strobe_q != '0);
    COV_CHATTER: cover property (@(posedge MCLK) disable iff (!RST_B)
        $fell(CHATTER_FILTER_ACTIVE_FLAG));
    COV_SUPPRESS: cover property (@(posedge MCLK) disable iff (!RST_B) (chg_w & limit_hit_w) != '0);
    COV_INTEGRATE: cover property (@(posedge MCLK) disable iff (!RST_B) BLOCK_INTEGRATE[3] && chg_w[24]);
endmodule : idf_input_filter
`default_nettype wire

//--- bench/idf_field_model.sv
// field contact model: presents the wanted contact levels on the pins
// assumes the bench changes a level at most once per sample tick
`timescale 1ns/1ns
`default_nettype none
module idf_field_model
    import idf_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [NUM_INPUTS-1:0] want,
    output logic [NUM_INPUTS-1:0] pins
);
    // contacts settle one clock after a request, like a relay behind a buffer
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pins <= '0;
        end else begin
            pins <= want;
        end
    end
endmodule : idf_field_model
`default_nettype wire

//--- bench/idf_input_filter_test.sv
// self-checking bench for the input debounce and chatter filter
// assumes a 10-cycle sample tick so that windows of 100 ticks stay short
`timescale 1ns/1ns
`default_nettype none
module idf_input_filter_test;
    import idf_pkg::*;
    localparam int TK = 10;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic [31:0] want = '0;
    logic [31:0] dis = '0;
    logic [31:0] inv = '0;
    logic [31:0] both = '0;
    logic [255:0] dbt = '0;
    logic [255:0] lim = '0;
    logic [127:0] win = '0;
    logic [7:0] mode = 8'hD8; // block 3 uses the spare code, read as binary
    logic [3:0] integ = 4'h8;
    logic [3:0] dech = 4'h4;
    logic [31:0] pins;
    logic tick;
    logic [31:0] bin;
    logic [31:0] strobe;
    logic [1023:0] cnt;
    logic flag;
    logic [15:0] status;
    int fail_count = 0;
    int cmp_count = 0;
    int cycles = 0;
    int gap = 0;
    int ev16 = 0;
    int ev17 = 0;
    bit seen_tick = 0;

    idf_field_model i_idf_field_model (.clk(mclk), .rst_b(rst_b), .want(want), .pins(pins));

    idf_input_filter #(.TICK_CYCLES_P(TK)) i_idf_input_filter (
        .MCLK(mclk), .RST_B(rst_b), .IN_PINS(pins), .IN_DISABLE(dis), .IN_INVERT(inv),
        .IN_BOTH_EDGES(both), .DEBOUNCE_TIME(dbt), .CHATTER_LIMIT(lim),
        .CHATTER_WINDOW(win), .BLOCK_MODE(mode), .BLOCK_INTEGRATE(integ),
        .BLOCK_DECHATTER(dech), .SAMPLE_TICK(tick), .BIN_VALUE(bin), .EVENT_STROBE(strobe),
        .COUNT_VALUES(cnt), .CHATTER_FILTER_ACTIVE_FLAG(flag), .STATUS_WORD(status)
    );

    initial begin
        forever #5 mclk = ~mclk;
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : conclude

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic chkb(input string what, input logic exp, input logic got);
        check(what, {31'h0, exp}, {31'h0, got});
    endtask : chkb

    // wait n ticks, then let the two-edge output pipeline settle
    task automatic ticks(input int n);
        repeat (n) @(posedge mclk iff tick === 1'b1);
        repeat (3) @(posedge mclk);
    endtask : ticks

    task automatic drive(input logic [31:0] m, input logic v);
        @(posedge mclk);
        want <= v ? (want | m) : (want & ~m);
    endtask : drive

    // strobe counters, tick spacing and hang guard
    always @(posedge mclk) begin
        cycles++;
        gap++;
        if (strobe[16] === 1'b1) ev16++;
        if (strobe[17] === 1'b1) ev17++;
        if (rst_b && tick === 1'b1) begin
            if (seen_tick) check("tick gap", TK, gap);
            seen_tick = 1;
            gap = 0;
        end
        if (cycles == 5000) begin
            fail_count++;
            $display("Error timeout expected end seen hang");
            conclude();
        end
    end

    initial begin
        dis[0] = 1'b1;
        inv[1] = 1'b1;
        dbt[2*8+:8] = 8'h03;
        dbt[24*8+:8] = 8'h02;
        both[9] = 1'b1;
        both[17:16] = 2'h3;
        lim[16*8+:8] = 8'h01;
        win[8*8+:8] = 8'h01;
        repeat (4) @(posedge mclk);
        rst_b <= 1'b1;
        // disabled pin held high, inverted pin held low, no debounce
        drive(32'h0000_0001, 1'b1);
        ticks(2);
        chkb("bin0", 1'b0, bin[0]);
        chkb("bin1", 1'b1, bin[1]);
        // stable mode, three ticks: level must hold four samples
        drive(32'h0000_0004, 1'b1);
        ticks(3);
        chkb("bin2 early", 1'b0, bin[2]);
        ticks(1);
        chkb("bin2 taken", 1'b1, bin[2]);
        // three low, one high, three low: the blip must restart timing
        drive(32'h0000_0004, 1'b0);
        ticks(3);
        drive(32'h0000_0004, 1'b1);
        ticks(1);
        drive(32'h0000_0004, 1'b0);
        ticks(3);
        chkb("bin2 restart", 1'b1, bin[2]);
        ticks(1);
        chkb("bin2 low", 1'b0, bin[2]);
        // integrating, two ticks: up, down, up, up reaches the time
        drive(32'h0100_0000, 1'b1);
        ticks(1);
        drive(32'h0100_0000, 1'b0);
        ticks(1);
        drive(32'h0100_0000, 1'b1);
        ticks(1);
        chkb("bin24 early", 1'b0, bin[24]);
        ticks(1);
        chkb("bin24 taken", 1'b1, bin[24]);
        check("count24", 32'h0000_0000, cnt[24*32+:32]);
        // counter block: three pulses, rising-only against both edges
        repeat (3) begin
            drive(32'h0000_0300, 1'b1);
            ticks(2);
            drive(32'h0000_0300, 1'b0);
            ticks(2);
        end
        check("count8", 32'h0000_0003, cnt[8*32+:32]);
        check("count9", 32'h0000_0006, cnt[9*32+:32]);
        // event block: limit one on input 16, none on its pair partner
        drive(32'h0003_0000, 1'b1);
        ticks(2);
        drive(32'h0003_0000, 1'b0);
        ticks(2);
        chkb("flag", 1'b1, flag);
        check("status", 32'h0000_0080, {16'h0000, status});
        chkb("bin16", 1'b0, bin[16]);
        check("ev16", 32'h1, 32'(ev16));
        check("ev17", 32'h2, 32'(ev17));
        ticks(95);
        chkb("flag held", 1'b1, flag);
        ticks(5);
        chkb("flag clear", 1'b0, flag);
        check("status clear", 32'h0000_0000, {16'h0000, status});
        drive(32'h0003_0000, 1'b1);
        ticks(2);
        check("ev16 again", 32'h2, 32'(ev16));
        check("ev17 again", 32'h3, 32'(ev17));
        conclude();
    end
endmodule : idf_input_filter_test
`default_nettype wire
